// file: rtl/lmc_cmd_handler.sv
// Link memory command handler: poke, block read/write, staged external
// transfers, link configuration and the host parallel port memory windows.
// Assumes one clock, a memory that answers each request with MEM_ACK, and
// link streams on the same clock.
// Functional notes
// - Poke writes one word, any address
// - Poke selector: direct, AND, OR
// - Parameters arrive in the command packet
// - Internal block read streams words out
// - Parallel port windows low and high
// - Block read addresses are not checked
// - Internal block write, no range check
// - External read stages, then streams out
// - External write stages, then copies out
// - Config changes baud on serial only
// - Command zero ignored, no response
`timescale 1ns/100ps
`include "lmc_defines.svh"

module lmc_cmd_handler (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire lmc_pkg::lmc_cmd_t CMD,
    input wire logic RX_VALID,
    output logic RX_READY,
    input wire logic [15:0] RX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [15:0] TX_DATA,
    output logic ACK_SENT,
    output lmc_pkg::lmc_mem_req_t MEM_OUT,
    input wire logic [15:0] MEM_RDATA,
    input wire logic MEM_ACK,
    input wire logic HP_REQ,
    input wire logic HP_WE,
    input wire logic [15:0] HP_ADDR,
    input wire logic [15:0] HP_WDATA,
    output logic HP_DONE,
    output logic HP_REJECT,
    output logic [15:0] HP_RDATA,
    output logic [15:0] SERIAL_SPEED
);

    lmc_pkg::lmc_state_t st_ff, nxt_st;
    lmc_pkg::lmc_mem_req_t mem_ff, nxt_mem;
    logic [15:0] op_ff, nxt_op;
    logic phase_ff, nxt_phase;
    logic [1:0] sel_ff, nxt_sel;
    logic [15:0] rd_ff, nxt_rd;
    logic [15:0] wr_ff, nxt_wr;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] len_ff, nxt_len;
    logic [15:0] addr_ff, nxt_addr;
    logic [15:0] stage_ff, nxt_stage;
    logic [15:0] buf_ff, nxt_buf;
    logic [15:0] baud_ff, nxt_baud;
    logic [15:0] hprd_ff, nxt_hprd;
    logic hpdone_ff, nxt_hpdone;
    logic hprej_ff, nxt_hprej;
    logic [15:0] merged;

    function automatic logic in_window(input logic [15:0] a);
        in_window = (a <= `LMC_HP_LOW_TOP) || (a >= `LMC_HP_HIGH_BASE);
    endfunction

    function automatic logic [15:0] step(input logic [15:0] v);
        step = v + 16'h0001;
    endfunction

    lmc_word_merge u_merge (
        .sel(sel_ff),
        .old_word(MEM_RDATA),
        .new_word(buf_ff),
        .merged(merged)
    );

    // Read data that leaves on the link, otherwise it is written back.
    logic to_link;
    logic from_link;
    logic last;
    assign to_link = (op_ff == `LMC_CMD_IRD) || ((op_ff == `LMC_CMD_XRD) && phase_ff);
    assign from_link = (op_ff == `LMC_CMD_IWR) || ((op_ff == `LMC_CMD_XWR) && !phase_ff);
    assign last = (cnt_ff == 16'h0001);

    always_comb begin
        nxt_st = st_ff;
        nxt_op = op_ff;
        nxt_phase = phase_ff;
        nxt_sel = sel_ff;
        nxt_rd = rd_ff;
        nxt_wr = wr_ff;
        nxt_cnt = cnt_ff;
        nxt_len = len_ff;
        nxt_addr = addr_ff;
        nxt_stage = stage_ff;
        nxt_buf = buf_ff;
        nxt_baud = baud_ff;
        nxt_hprd = hprd_ff;
        nxt_hpdone = 1'b0;
        nxt_hprej = 1'b0;
        case (st_ff)
            lmc_pkg::LMC_ST_IDLE: begin
                if (CMD_VALID) begin
                    nxt_op = CMD.command;
                    nxt_phase = 1'b0;
                    nxt_sel = CMD.write_logic_select;
                    nxt_len = CMD.word_count;
                    nxt_cnt = CMD.word_count;
                    nxt_addr = CMD.target_address;
                    nxt_stage = CMD.staging_pointer;
                    nxt_buf = CMD.poke_data;
                    nxt_rd = CMD.target_address;
                    nxt_wr = CMD.target_address;
                    case (CMD.command)
                        `LMC_CMD_NONE: nxt_st = lmc_pkg::LMC_ST_IDLE;
                        `LMC_CMD_POKE: begin
                            nxt_cnt = 16'h0001;
                            if (CMD.write_logic_select == `LMC_LOGIC_DIRECT) begin
                                nxt_st = lmc_pkg::LMC_ST_MEM_WR;
                            end else begin
                                nxt_st = lmc_pkg::LMC_ST_POKE_RD;
                            end
                        end
                        `LMC_CMD_IRD: nxt_st = lmc_pkg::LMC_ST_MEM_RD;
                        `LMC_CMD_IWR: nxt_st = lmc_pkg::LMC_ST_LINK_RX;
                        `LMC_CMD_XRD: begin
                            nxt_wr = CMD.staging_pointer;
                            nxt_st = lmc_pkg::LMC_ST_MEM_RD;
                        end
                        `LMC_CMD_XWR: begin
                            nxt_wr = CMD.staging_pointer;
                            nxt_st = lmc_pkg::LMC_ST_LINK_RX;
                        end
                        `LMC_CMD_CFG: begin
                            if (CMD.transport == lmc_pkg::LMC_TP_SERIAL) begin
                                nxt_baud = CMD.serial_speed_setting;
                            end
                            nxt_st = lmc_pkg::LMC_ST_SEND_ACK;
                        end
                        default: nxt_st = lmc_pkg::LMC_ST_SEND_ACK;
                    endcase
                    if (CMD.command != `LMC_CMD_NONE && CMD.command != `LMC_CMD_POKE &&
                        CMD.command != `LMC_CMD_CFG && CMD.word_count == 16'h0000) begin
                        nxt_st = lmc_pkg::LMC_ST_SEND_ACK;
                    end
                    if (nxt_st == lmc_pkg::LMC_ST_SEND_ACK) begin
                        nxt_buf = `LMC_ACK_CODE;
                    end
                end else if (HP_REQ && !hpdone_ff) begin
                    // A request still held during the done pulse is the old one, not a new one.
                    // outside windows refused
                    if (in_window(HP_ADDR)) begin
                        nxt_st = lmc_pkg::LMC_ST_HP_ACC;
                    end else begin
                        nxt_hpdone = 1'b1;
                        nxt_hprej = 1'b1;
                    end
                end
            end
            lmc_pkg::LMC_ST_POKE_RD: begin
                if (MEM_ACK) begin
                    nxt_buf = merged;
                    nxt_st = lmc_pkg::LMC_ST_MEM_WR;
                end
            end
            lmc_pkg::LMC_ST_MEM_RD: begin
                if (MEM_ACK) begin
                    nxt_buf = MEM_RDATA;
                    nxt_rd = step(rd_ff);
                    nxt_st = to_link ? lmc_pkg::LMC_ST_LINK_TX : lmc_pkg::LMC_ST_MEM_WR;
                end
            end
            lmc_pkg::LMC_ST_LINK_RX: begin
                if (RX_VALID) begin
                    nxt_buf = RX_DATA;
                    nxt_st = lmc_pkg::LMC_ST_MEM_WR;
                end
            end
            lmc_pkg::LMC_ST_LINK_TX: begin
                if (TX_READY) begin
                    nxt_cnt = cnt_ff - 16'h0001;
                    if (last) begin
                        nxt_buf = `LMC_ACK_CODE;
                        nxt_st = lmc_pkg::LMC_ST_SEND_ACK;
                    end else begin
                        nxt_st = lmc_pkg::LMC_ST_MEM_RD;
                    end
                end
            end
            lmc_pkg::LMC_ST_MEM_WR: begin
                if (MEM_ACK) begin
                    nxt_wr = step(wr_ff);
                    nxt_cnt = cnt_ff - 16'h0001;
                    if (last) begin
                        if (!phase_ff && (op_ff == `LMC_CMD_XRD || op_ff == `LMC_CMD_XWR)) begin
                            nxt_phase = 1'b1;
                            nxt_cnt = len_ff;
                            nxt_rd = stage_ff;
                            nxt_wr = addr_ff;
                            nxt_st = lmc_pkg::LMC_ST_MEM_RD;
                        end else begin
                            nxt_buf = `LMC_ACK_CODE;
                            nxt_st = lmc_pkg::LMC_ST_SEND_ACK;
                        end
                    end else begin
                        nxt_st = from_link ? lmc_pkg::LMC_ST_LINK_RX : lmc_pkg::LMC_ST_MEM_RD;
                    end
                end
            end
            lmc_pkg::LMC_ST_HP_ACC: begin
                if (MEM_ACK) begin
                    nxt_hprd = MEM_RDATA;
                    nxt_hpdone = 1'b1;
                    nxt_st = lmc_pkg::LMC_ST_IDLE;
                end
            end
            lmc_pkg::LMC_ST_SEND_ACK: begin
                if (TX_READY) begin
                    nxt_st = lmc_pkg::LMC_ST_IDLE;
                end
            end
            default: nxt_st = lmc_pkg::LMC_ST_IDLE;
        endcase
        // Memory request follows the state being entered.
        nxt_mem = '0;
        case (nxt_st)
            lmc_pkg::LMC_ST_POKE_RD: nxt_mem = '{1'b1, 1'b0, nxt_wr, 16'h0000};
            lmc_pkg::LMC_ST_MEM_RD: nxt_mem = '{1'b1, 1'b0, nxt_rd, 16'h0000};
            lmc_pkg::LMC_ST_MEM_WR: nxt_mem = '{1'b1, 1'b1, nxt_wr, nxt_buf};
            lmc_pkg::LMC_ST_HP_ACC: begin
                if (st_ff == lmc_pkg::LMC_ST_HP_ACC) begin
                    nxt_mem = mem_ff;
                end else begin
                    nxt_mem = '{1'b1, HP_WE, HP_ADDR, HP_WDATA};
                end
            end
            default: nxt_mem = '0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_ff <= lmc_pkg::LMC_ST_IDLE;
            mem_ff <= '0;
            op_ff <= `LMC_CMD_NONE;
            phase_ff <= 1'b0;
            sel_ff <= `LMC_LOGIC_DIRECT;
            rd_ff <= `LMC_WORD_RESET;
            wr_ff <= `LMC_WORD_RESET;
            cnt_ff <= `LMC_WORD_RESET;
            len_ff <= `LMC_WORD_RESET;
            addr_ff <= `LMC_WORD_RESET;
            stage_ff <= `LMC_WORD_RESET;
            buf_ff <= `LMC_WORD_RESET;
            baud_ff <= `LMC_BAUD_RESET;
            hprd_ff <= `LMC_WORD_RESET;
            hpdone_ff <= 1'b0;
            hprej_ff <= 1'b0;
        end else if (CE) begin
            st_ff <= nxt_st;
            mem_ff <= nxt_mem;
            op_ff <= nxt_op;
            phase_ff <= nxt_phase;
            sel_ff <= nxt_sel;
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            cnt_ff <= nxt_cnt;
            len_ff <= nxt_len;
            addr_ff <= nxt_addr;
            stage_ff <= nxt_stage;
            buf_ff <= nxt_buf;
            baud_ff <= nxt_baud;
            hprd_ff <= nxt_hprd;
            hpdone_ff <= nxt_hpdone;
            hprej_ff <= nxt_hprej;
        end
    end

    assign CMD_READY = CE && (st_ff == lmc_pkg::LMC_ST_IDLE);
    assign RX_READY = CE && (st_ff == lmc_pkg::LMC_ST_LINK_RX);
    assign TX_VALID = (st_ff == lmc_pkg::LMC_ST_LINK_TX) || (st_ff == lmc_pkg::LMC_ST_SEND_ACK);
    assign TX_DATA = buf_ff;
    assign ACK_SENT = CE && TX_READY && (st_ff == lmc_pkg::LMC_ST_SEND_ACK);
    assign MEM_OUT = mem_ff;
    assign HP_DONE = hpdone_ff;
    assign HP_REJECT = hprej_ff;
    assign HP_RDATA = hprd_ff;
    assign SERIAL_SPEED = baud_ff;

endmodule

// file: rtl/lmc_defines.svh
// Constants of the link memory command handler: codes, fields, windows, reset values.
// Assumes inclusion by bare name from the handler's design files.
`ifndef LMC_DEFINES_SVH
`define LMC_DEFINES_SVH

// Command codes on the command port; the values are arbitrary, zero means no command.
`define LMC_CMD_NONE 16'h0000
`define LMC_CMD_POKE 16'h0001
`define LMC_CMD_IRD 16'h0002
`define LMC_CMD_IWR 16'h0003
`define LMC_CMD_XRD 16'h0004
`define LMC_CMD_XWR 16'h0005
`define LMC_CMD_CFG 16'h0006

// Write-logic selector values for a poke.
`define LMC_LOGIC_DIRECT 2'h0
`define LMC_LOGIC_AND 2'h1
`define LMC_LOGIC_OR 2'h2

// Word sent on the link when a command has completed; the value is arbitrary.
`define LMC_ACK_CODE 16'h0FED

// Direct windows of the host parallel port into internal memory.
`define LMC_HP_LOW_TOP 16'h3FFF
`define LMC_HP_HIGH_BASE 16'hE000

// Reset values.
`define LMC_BAUD_RESET 16'h0000
`define LMC_WORD_RESET 16'h0000

`endif

// file: rtl/lmc_pkg.sv
// Types shared by the link memory command handler, its memory model and its bench.
// Assumes lmc_defines.svh holds the numeric constants.
package lmc_pkg;

    typedef enum logic [1:0] {
        LMC_TP_PARALLEL = 2'b00,
        LMC_TP_SERIAL = 2'b01,
        LMC_TP_SPI = 2'b10
    } lmc_transport_t;

    typedef struct packed {
        logic [15:0] command;
        lmc_transport_t transport;
        logic [15:0] target_address;
        logic [15:0] word_count;
        logic [15:0] staging_pointer;
        logic [15:0] poke_data;
        logic [1:0] write_logic_select;
        logic [15:0] serial_speed_setting;
    } lmc_cmd_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } lmc_mem_req_t;

    typedef enum logic [3:0] {
        LMC_ST_IDLE = 4'b0000,
        LMC_ST_POKE_RD = 4'b0001,
        LMC_ST_MEM_RD = 4'b0010,
        LMC_ST_MEM_WR = 4'b0011,
        LMC_ST_LINK_TX = 4'b0100,
        LMC_ST_LINK_RX = 4'b0101,
        LMC_ST_HP_ACC = 4'b0110,
        LMC_ST_SEND_ACK = 4'b0111
    } lmc_state_t;

endpackage

// file: rtl/lmc_word_merge.sv
// Combines a poke word with the current memory contents.
// Assumes the caller supplies the word read back from the target address.
`timescale 1ns/100ps
`include "lmc_defines.svh"

module lmc_word_merge (
    input wire logic [1:0] sel,
    input wire logic [15:0] old_word,
    input wire logic [15:0] new_word,
    output logic [15:0] merged
);

    always_comb begin
        case (sel)
            `LMC_LOGIC_AND: merged = old_word & new_word;
            `LMC_LOGIC_OR: merged = old_word | new_word;
            default: merged = new_word;
        endcase
    end

endmodule

// file: bench/lmc_mem_model.sv
// Word memory standing in for the handler's memory port.
// Assumes each request stays held until the acknowledge pulse.
`timescale 1ns/100ps
module lmc_mem_model (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [3:0] LAT,
    input wire lmc_pkg::lmc_mem_req_t MEM_OUT,
    output logic [15:0] MEM_RDATA,
    output logic MEM_ACK
);
    logic [15:0] mem [0:65535];
    logic [3:0] cnt = 4'h0;
    initial begin
        MEM_RDATA = 16'h0000;
        MEM_ACK = 1'b0;
    end
    always @(posedge CLK) begin
        MEM_ACK <= 1'b0;
        MEM_RDATA <= ~MEM_RDATA;
        cnt <= 4'h0;
        if (RST_N && MEM_OUT.req && !MEM_ACK) begin
            if (cnt >= LAT) begin
                MEM_ACK <= 1'b1;
                if (MEM_OUT.we) mem[MEM_OUT.addr] <= MEM_OUT.wdata;
                else MEM_RDATA <= mem[MEM_OUT.addr];
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// file: bench/lmc_cmd_handler_chk.sv
// Port checker for the link memory command handler.
// Assumes a bind from the bench top and one clock domain.
`timescale 1ns/100ps
`include "lmc_defines.svh"
module lmc_cmd_handler_chk (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic CMD_VALID,
    input wire logic CMD_READY,
    input wire lmc_pkg::lmc_cmd_t CMD,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic [15:0] TX_DATA,
    input wire logic ACK_SENT,
    input wire lmc_pkg::lmc_mem_req_t MEM_OUT,
    input wire logic MEM_ACK,
    input wire logic [15:0] HP_ADDR,
    input wire logic HP_DONE,
    input wire logic HP_REJECT,
    input wire logic [15:0] SERIAL_SPEED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_take(logic [15:0] code);
        CMD_VALID && CMD_READY && CMD.command == code;
    endsequence
    sequence s_cfg_serial;
        s_take(`LMC_CMD_CFG) ##0 CMD.transport == lmc_pkg::LMC_TP_SERIAL;
    endsequence
    property p_ack_word;
        ACK_SENT |-> TX_VALID && TX_READY && TX_DATA == `LMC_ACK_CODE;
    endproperty
    property p_zero;
        s_take(`LMC_CMD_NONE) |=> !TX_VALID [*3];
    endproperty
    property p_poke_dir;
        s_take(`LMC_CMD_POKE) ##0 CMD.write_logic_select == `LMC_LOGIC_DIRECT |=> MEM_OUT.req
            && MEM_OUT.we && MEM_OUT.addr == $past(CMD.target_address)
            && MEM_OUT.wdata == $past(CMD.poke_data);
    endproperty
    property p_poke_rd;
        s_take(`LMC_CMD_POKE) ##0 CMD.write_logic_select inside {2'h1, 2'h2}
            |=> MEM_OUT.req && !MEM_OUT.we && MEM_OUT.addr == $past(CMD.target_address);
    endproperty
    property p_cfg_set;
        s_cfg_serial |=> SERIAL_SPEED == $past(CMD.serial_speed_setting);
    endproperty
    property p_cfg_keep;
        s_take(`LMC_CMD_CFG) ##0 CMD.transport != lmc_pkg::LMC_TP_SERIAL |=> $stable(SERIAL_SPEED);
    endproperty
    property p_hp_rej;
        HP_REJECT |-> HP_DONE && HP_ADDR > `LMC_HP_LOW_TOP && HP_ADDR < `LMC_HP_HIGH_BASE;
    endproperty
    property p_hp_win;
        HP_DONE && !HP_REJECT |-> HP_ADDR <= `LMC_HP_LOW_TOP || HP_ADDR >= `LMC_HP_HIGH_BASE;
    endproperty
    property p_mem_hold;
        MEM_OUT.req && !MEM_ACK |=> MEM_OUT == $past(MEM_OUT);
    endproperty
    a_ack_word: assert property (p_ack_word)
        else $error("ack pulse without ack word");
    a_zero: assert property (p_zero)
        else $error("zero command answered");
    a_poke_dir: assert property (p_poke_dir)
        else $error("direct poke write wrong");
    a_poke_rd: assert property (p_poke_rd)
        else $error("poke merge read missing");
    a_cfg_set: assert property (p_cfg_set)
        else $error("serial speed not taken");
    a_cfg_keep: assert property (p_cfg_keep)
        else $error("serial speed changed off serial");
    a_hp_rej: assert property (p_hp_rej)
        else $error("reject inside window");
    a_hp_win: assert property (p_hp_win)
        else $error("access outside window");
    a_mem_hold: assert property (p_mem_hold)
        else $error("memory request changed early");
endmodule

// file: bench/lmc_cmd_handler_tb.sv
// Self-checking bench for the link memory command handler.
// Assumes lmc_mem_model as memory; the bench plays the link master.
`timescale 1ns/100ps
`include "lmc_defines.svh"
module lmc_cmd_handler_tb;
    logic CLK = 0, RST_N = 0, CE = 1, CMD_VALID = 0, RX_VALID = 0, TX_READY = 1;
    logic CMD_READY, RX_READY, TX_VALID, ACK_SENT, MEM_ACK, HP_DONE, HP_REJECT;
    logic HP_REQ = 0, HP_WE = 0, stall = 0;
    logic [3:0] lat = 4'h0;
    logic [15:0] RX_DATA = 0, TX_DATA, MEM_RDATA, HP_ADDR = 0, HP_WDATA = 0;
    logic [15:0] HP_RDATA, SERIAL_SPEED;
    lmc_pkg::lmc_cmd_t CMD = '0;
    lmc_pkg::lmc_mem_req_t MEM_OUT;
    logic [15:0] txq[$], rxq[$];
    int errors = 0, n_checks = 0, n_ack = 0;
    lmc_cmd_handler i_dut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .CMD_VALID(CMD_VALID),
        .CMD_READY(CMD_READY), .CMD(CMD), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
        .RX_DATA(RX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
        .ACK_SENT(ACK_SENT), .MEM_OUT(MEM_OUT), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK),
        .HP_REQ(HP_REQ), .HP_WE(HP_WE), .HP_ADDR(HP_ADDR), .HP_WDATA(HP_WDATA),
        .HP_DONE(HP_DONE), .HP_REJECT(HP_REJECT), .HP_RDATA(HP_RDATA),
        .SERIAL_SPEED(SERIAL_SPEED));
    lmc_mem_model i_mem (.CLK(CLK), .RST_N(RST_N), .LAT(lat), .MEM_OUT(MEM_OUT),
        .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));
    initial begin
        forever #4 CLK = ~CLK;
    end
    // Link partner: counts acks, collects TX words, feeds RX words.
    always @(posedge CLK) begin
        if (ACK_SENT === 1'b1) n_ack <= n_ack + 1;
        if (TX_VALID === 1'b1 && TX_READY === 1'b1) txq.push_back(TX_DATA);
        TX_READY <= stall ? ~TX_READY : 1'b1;
        if (RX_VALID === 1'b1 && RX_READY === 1'b1) void'(rxq.pop_front());
        RX_VALID <= rxq.size() != 0;
        RX_DATA <= rxq.size() != 0 ? rxq[0] : ~RX_DATA;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic lmc_pkg::lmc_cmd_t mk(input logic [15:0] op, a, n, s, d,
        input logic [1:0] sel);
        mk = '{op, lmc_pkg::LMC_TP_SERIAL, a, n, s, d, sel, 16'h0000};
    endfunction
    task automatic issue(input lmc_pkg::lmc_cmd_t c);
        int k = 0;
        txq.delete();
        CMD <= c;
        CMD_VALID <= 1'b1;
        do @(posedge CLK); while (CMD_READY !== 1'b1 && ++k < 500);
        CMD_VALID <= 1'b0;
    endtask
    task automatic run(input lmc_pkg::lmc_cmd_t c, input int nw);
        int a = n_ack;
        int k = 0;
        issue(c);
        while (n_ack == a && k++ < 3000) @(posedge CLK);
        @(posedge CLK);
        chk(16'(txq.size()), 16'(nw + 1));
        chk(txq[nw], `LMC_ACK_CODE);
        repeat (3750) @(posedge CLK);
    endtask
    task automatic t_poke;
        logic [15:0] adr[4] = '{16'hFFFF, 16'h0000, 16'h8000, 16'h3FFF};
        logic [15:0] exp[4] = '{16'h3C3C, 16'h3030, 16'hFCFC, 16'h3C3C};
        lat <= 4'h3;
        for (int i = 0; i < 4; i++) begin
            i_mem.mem[adr[i]] = 16'hF0F0;
            run(mk(`LMC_CMD_POKE, adr[i], 16'h0000, 16'h0000, 16'h3C3C, 2'(i)), 0);
            chk(i_mem.mem[adr[i]], exp[i]);
        end
        $display("poke done");
    endtask
    task automatic t_blocks;
        lat <= 4'h1;
        stall <= 1'b1;
        for (int i = 0; i < 3; i++) i_mem.mem[16'h4000 + i] = 16'hA000 + 16'(i);
        run(mk(`LMC_CMD_IRD, 16'h4000, 16'h0003, 16'h0000, 16'h0000, 2'h0), 3);
        for (int i = 0; i < 3; i++) chk(txq[i], 16'hA000 + 16'(i));
        rxq = '{16'h1111, 16'h2222};
        run(mk(`LMC_CMD_IWR, 16'h1000, 16'h0002, 16'h0000, 16'h0000, 2'h0), 0);
        chk(i_mem.mem[16'h1001], 16'h2222);
        i_mem.mem[16'h9000] = 16'hB001;
        i_mem.mem[16'h9001] = 16'hB002;
        run(mk(`LMC_CMD_XRD, 16'h9000, 16'h0002, 16'h0100, 16'h0000, 2'h0), 2);
        chk(i_mem.mem[16'h0101], 16'hB002);
        chk(txq[1], 16'hB002);
        rxq = '{16'hC001, 16'hC002};
        run(mk(`LMC_CMD_XWR, 16'hC000, 16'h0002, 16'h0200, 16'h0000, 2'h0), 0);
        chk(i_mem.mem[16'h0200], 16'hC001);
        chk(i_mem.mem[16'hC001], 16'hC002);
        stall <= 1'b0;
        $display("blocks done");
    endtask
    task automatic t_cfg;
        lmc_pkg::lmc_cmd_t c = mk(`LMC_CMD_CFG, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 2'h0);
        c.serial_speed_setting = 16'h1234;
        run(c, 0);
        chk(SERIAL_SPEED, 16'h1234);
        repeat (8750) @(posedge CLK);
        c.transport = lmc_pkg::LMC_TP_SPI;
        c.serial_speed_setting = 16'h5678;
        run(c, 0);
        chk(SERIAL_SPEED, 16'h1234);
        // Unknown command and an empty block read are answered with the ack word only.
        run(mk(16'h0007, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 2'h0), 0);
        run(mk(`LMC_CMD_IRD, 16'h4000, 16'h0000, 16'h0000, 16'h0000, 2'h0), 0);
        issue(mk(`LMC_CMD_NONE, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 2'h0));
        repeat (20) @(posedge CLK);
        chk(16'(txq.size()), 16'h0000);
        $display("config done");
    endtask
    task automatic hp(input logic we, input logic [15:0] a, d, input logic rej);
        int k = 0;
        HP_REQ <= 1'b1;
        HP_WE <= we;
        HP_ADDR <= a;
        HP_WDATA <= d;
        do @(posedge CLK); while (HP_DONE !== 1'b1 && ++k < 200);
        HP_REQ <= 1'b0;
        chk({15'h0000, HP_DONE}, 16'h0001);
        chk({15'h0000, HP_REJECT}, {15'h0000, rej});
        if (!we && !rej) chk(HP_RDATA, d);
        @(posedge CLK);
    endtask
    task automatic t_hp;
        i_mem.mem[16'h3FFF] = 16'h1357;
        hp(1'b1, 16'hE000, 16'h5A5A, 1'b0);
        hp(1'b0, 16'hE000, 16'h5A5A, 1'b0);
        hp(1'b0, 16'h3FFF, 16'h1357, 1'b0);
        hp(1'b1, 16'h4000, 16'h0000, 1'b1);
        hp(1'b0, 16'hDFFF, 16'h0000, 1'b1);
        $display("parallel port done");
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        t_poke;
        t_blocks;
        t_cfg;
        t_hp;
        close_out;
    end
    initial begin
        #700000;
        errors++;
        close_out;
    end
endmodule
bind lmc_cmd_handler lmc_cmd_handler_chk i_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE),
    .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_DATA(TX_DATA), .ACK_SENT(ACK_SENT), .MEM_OUT(MEM_OUT),
    .MEM_ACK(MEM_ACK), .HP_ADDR(HP_ADDR), .HP_DONE(HP_DONE), .HP_REJECT(HP_REJECT),
    .SERIAL_SPEED(SERIAL_SPEED));
